// [logic/tai_indicators.sv]
// tai_indicators: front-panel indicator drive and alarm response commands.
// assumes all status inputs synchronous to clk; one sync reset.
`timescale 1ns/10ps
module tai_indicators #(
  parameter int unsigned HALF_PERIOD = tai_pkg::HALF_PERIOD_CYC,
  parameter int unsigned SETUP_HOLD = tai_pkg::SETUP_HOLD_CYC,
  parameter int unsigned STRETCH = tai_pkg::STRETCH_CYC
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic [tai_pkg::NUM_GROUPS-1:0] group_installed, // group fitted
  input wire logic [tai_pkg::NUM_PORTS-1:0] modem_good, // per-modem health
  input wire logic [tai_pkg::NUM_PORTS-1:0] modem_carrier, // carrier seen
  input wire logic [tai_pkg::NUM_PORTS-1:0] modem_tx_evt, // tx activity
  input wire logic [tai_pkg::NUM_PORTS-1:0] modem_rx_evt, // rx activity
  input wire logic net_loopback, // network loopback active
  input wire logic net_locked, // engine locked to rx signal
  input wire logic net_framed, // valid framing received
  input wire logic net_no_pulses, // no pulses at receiver
  input wire logic net_carrier_fail, // local carrier failure
  input wire logic net_yellow_rx, // yellow alarm received
  input wire logic net_ais_rx, // all-ones signal received
  input wire logic net_connected, // engine connected to line
  input wire logic di_frame_sync, // drop-insert frame sync
  input wire logic attention_needed, // operator attention needed
  input wire logic problem_present, // problem present
  input wire logic diag_passed, // core diagnostics passed
  input wire logic module_reset_seen, // module has been reset
  input wire logic lan_evt, // successful lan tx or rx
  input wire logic setup_button, // setup button pressed
  input wire logic [tai_pkg::NUM_ETH_CH-1:0] eth_channel_sel, // channel
  output logic [1:0] group_color [tai_pkg::NUM_GROUPS], // off/green/amber
  output logic [tai_pkg::NUM_PORTS-1:0] modem_carrier_present, // carrier
  output logic [tai_pkg::NUM_PORTS-1:0] modem_tx_indicator, // tx flash
  output logic [tai_pkg::NUM_PORTS-1:0] modem_rx_indicator, // rx flash
  output logic test_indicator, // red loopback
  output logic sync_indicator, // green sync
  output logic los_indicator, // red loss of signal
  output logic red_alarm_indicator, // red alarm
  output logic remote_alarm_indicator, // yellow alarm received
  output logic all_ones_alarm_indicator, // blue alarm
  output logic online_indicator, // green online
  output logic drop_insert_frame_lock, // green drop-insert sync
  output logic attention_indicator, // amber attention
  output logic status_indicator, // green status
  output logic lan_activity_indicator, // green traffic
  output logic setup_indicator, // green setup
  output logic [tai_pkg::NUM_ETH_CH-1:0] eth_channel_indicator, // a,b,c
  output logic setup_reset_mode, // button held long: reset mode
  output logic tx_net_ais, // command all-ones toward network
  output logic tx_yellow_alarm, // command yellow alarm toward network
  output logic tx_di_keepalive // command keep-alive toward drop-insert
);
  import tai_pkg::*;
  localparam int unsigned HW = $clog2(HALF_PERIOD + 1);
  localparam int unsigned NE = 2 * NUM_PORTS + 1;

  // flash timebase
  logic [HW-1:0] half_cnt_q;
  logic [HW-1:0] half_cnt_d;
  logic blink_q;
  logic blink_d;
  // setup button tracking
  tai_setup_type setup_q;
  tai_setup_type setup_d;
  logic [BIG_CNT_W-1:0] hold_q;
  logic [BIG_CNT_W-1:0] hold_d;
  // registered indicator values
  logic [1:0] grp_q [NUM_GROUPS];
  logic [1:0] grp_d [NUM_GROUPS];
  logic [NUM_PORTS-1:0] carrier_q;
  logic [NUM_PORTS-1:0] carrier_d;
  // network status lamps
  logic test_lamp_q;
  logic test_lamp_d;
  logic sync_lamp_q;
  logic sync_lamp_d;
  logic los_lamp_q;
  logic los_lamp_d;
  logic red_lamp_q;
  logic red_lamp_d;
  logic remote_lamp_q;
  logic remote_lamp_d;
  logic ais_lamp_q;
  logic ais_lamp_d;
  logic online_lamp_q;
  logic online_lamp_d;
  logic di_lock_lamp_q;
  logic di_lock_lamp_d;
  // system lamps and setup mode
  logic attention_lamp_q;
  logic attention_lamp_d;
  logic status_lamp_q;
  logic status_lamp_d;
  logic setup_lamp_q;
  logic setup_lamp_d;
  logic reset_mode_q;
  logic reset_mode_d;
  // alarm responses commanded toward the engine, and ethernet channel select
  logic send_ais_q;
  logic send_ais_d;
  logic send_yellow_q;
  logic send_yellow_d;
  logic send_keepalive_q;
  logic send_keepalive_d;
  logic [NUM_ETH_CH-1:0] eth_q;
  logic [NUM_ETH_CH-1:0] eth_d;

  tai_stretch_if #(.N(NE)) act_if ();

  // activity events into stretcher
  assign act_if.event_in = {lan_evt, modem_rx_evt, modem_tx_evt};

  tai_stretch #(.N(NE), .HOLD_CYC(STRETCH)) u_stretch (
    .clk(clk),
    .sys_rst(sys_rst),
    .sif(act_if)
  );

  always_comb begin
    half_cnt_d = half_cnt_q + HW'(1);
    blink_d = blink_q;
    if (half_cnt_q >= HW'(HALF_PERIOD - 1)) begin
      half_cnt_d = '0;
      blink_d = ~blink_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half_cnt_q <= '0;
      blink_q <= 1'b0;
    end else begin
      half_cnt_q <= half_cnt_d;
      blink_q <= blink_d;
    end
  end

  always_comb begin
    setup_d = setup_q;
    hold_d = hold_q;
    if (!setup_button) begin
      setup_d = TAI_SETUP_IDLE;
      hold_d = '0;
    end else begin
      unique case (setup_q)
        TAI_SETUP_IDLE: begin
          setup_d = TAI_SETUP_MODE;
          hold_d = BIG_CNT_W'(1);
        end
        TAI_SETUP_MODE: begin
          hold_d = hold_q + BIG_CNT_W'(1);
          if (hold_q >= BIG_CNT_W'(SETUP_HOLD - 1)) begin
            setup_d = TAI_SETUP_RESET;
          end
        end
        TAI_SETUP_RESET: begin
          hold_d = hold_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setup_q <= TAI_SETUP_IDLE;
      hold_q <= '0;
    end else begin
      setup_q <= setup_d;
      hold_q <= hold_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
      always_comb begin
        if (!group_installed[g]) begin
          grp_d[g] = COLOR_OFF;
        end else if (&modem_good[g*GROUP_SIZE +: GROUP_SIZE]) begin
          grp_d[g] = COLOR_GREEN;
        end else begin
          grp_d[g] = COLOR_AMBER;
        end
      end
    end
  endgenerate

  // indicator next values
  always_comb begin
    carrier_d = modem_carrier;
    eth_d = eth_channel_sel;
    test_lamp_d = net_loopback;
    sync_lamp_d = net_locked & net_framed;
    los_lamp_d = net_no_pulses;
    red_lamp_d = net_carrier_fail;
    remote_lamp_d = net_yellow_rx;
    ais_lamp_d = net_ais_rx;
    online_lamp_d = net_connected;
    di_lock_lamp_d = di_frame_sync;
    attention_lamp_d = problem_present ? blink_q : attention_needed;
    status_lamp_d = diag_passed ? 1'b1 : (module_reset_seen & blink_q);
    setup_lamp_d = (setup_d == TAI_SETUP_MODE) |
                   ((setup_d == TAI_SETUP_RESET) & blink_q);
    reset_mode_d = (setup_d == TAI_SETUP_RESET);
    send_ais_d = net_no_pulses;
    send_yellow_d = net_carrier_fail;
    send_keepalive_d = ~di_frame_sync;
  end

  // register every lamp and command except the stretched activity lamps, all dark in reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int k = 0; k < NUM_GROUPS; k++) begin
        grp_q[k] <= COLOR_OFF;
      end
      carrier_q <= '0;
      eth_q <= '0;
      test_lamp_q <= 1'b0;
      sync_lamp_q <= 1'b0;
      los_lamp_q <= 1'b0;
      red_lamp_q <= 1'b0;
      remote_lamp_q <= 1'b0;
      ais_lamp_q <= 1'b0;
      online_lamp_q <= 1'b0;
      di_lock_lamp_q <= 1'b0;
      attention_lamp_q <= 1'b0;
      status_lamp_q <= 1'b0;
      setup_lamp_q <= 1'b0;
      reset_mode_q <= 1'b0;
      send_ais_q <= 1'b0;
      send_yellow_q <= 1'b0;
      send_keepalive_q <= 1'b0;
    end else begin
      grp_q <= grp_d;
      carrier_q <= carrier_d;
      eth_q <= eth_d;
      test_lamp_q <= test_lamp_d;
      sync_lamp_q <= sync_lamp_d;
      los_lamp_q <= los_lamp_d;
      red_lamp_q <= red_lamp_d;
      remote_lamp_q <= remote_lamp_d;
      ais_lamp_q <= ais_lamp_d;
      online_lamp_q <= online_lamp_d;
      di_lock_lamp_q <= di_lock_lamp_d;
      attention_lamp_q <= attention_lamp_d;
      status_lamp_q <= status_lamp_d;
      setup_lamp_q <= setup_lamp_d;
      reset_mode_q <= reset_mode_d;
      send_ais_q <= send_ais_d;
      send_yellow_q <= send_yellow_d;
      send_keepalive_q <= send_keepalive_d;
    end
  end

  // output mapping
  assign group_color = grp_q;
  assign modem_carrier_present = carrier_q;
  assign modem_tx_indicator = act_if.lit[NUM_PORTS-1:0];
  assign modem_rx_indicator = act_if.lit[2*NUM_PORTS-1:NUM_PORTS];
  assign lan_activity_indicator = act_if.lit[NE-1];
  // network and alarm lamps
  assign test_indicator = test_lamp_q;
  assign sync_indicator = sync_lamp_q;
  assign los_indicator = los_lamp_q;
  assign red_alarm_indicator = red_lamp_q;
  assign remote_alarm_indicator = remote_lamp_q;
  assign all_ones_alarm_indicator = ais_lamp_q;
  assign online_indicator = online_lamp_q;
  assign drop_insert_frame_lock = di_lock_lamp_q;
  // system lamps
  assign attention_indicator = attention_lamp_q;
  assign status_indicator = status_lamp_q;
  assign setup_indicator = setup_lamp_q;
  assign setup_reset_mode = reset_mode_q;
  // alarm response commands and ethernet channel lamps
  assign tx_net_ais = send_ais_q;
  assign tx_yellow_alarm = send_yellow_q;
  assign tx_di_keepalive = send_keepalive_q;
  assign eth_channel_indicator = eth_q;
endmodule

// [logic/tai_pkg.sv]
// tai_pkg: constants shared by the indicator logic and its stretcher.
// assumes a single 125 MHz system clock.
package tai_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned NUM_PORTS = 24;
  localparam int unsigned NUM_GROUPS = 3;
  localparam int unsigned GROUP_SIZE = 8;
  localparam int unsigned NUM_ETH_CH = 3;
  // regular flash rate, setup hold time and activity stretch time
  localparam int unsigned FLASH_HZ = 1;
  localparam int unsigned SETUP_HOLD_S = 3;
  localparam int unsigned STRETCH_MS = 50;
  localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned SETUP_HOLD_CYC = CLK_HZ * SETUP_HOLD_S;
  localparam int unsigned STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
  localparam int unsigned BIG_CNT_W = 32;
  localparam logic [1:0] COLOR_OFF = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_AMBER = 2'h2;
  typedef enum logic [1:0] {TAI_SETUP_IDLE, TAI_SETUP_MODE, TAI_SETUP_RESET}
    tai_setup_type;
endpackage

// [logic/tai_stretch.sv]
// tai_stretch: per-bit pulse stretcher for activity indicators.
// assumes synchronous active-high reset on sys_rst.
`timescale 1ns/10ps
module tai_stretch #(
  parameter int unsigned N = 1,
  parameter int unsigned HOLD_CYC = tai_pkg::STRETCH_CYC
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  tai_stretch_if.stretcher sif // events in, lit levels out
);
  import tai_pkg::*;
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_q [N];
  logic [CW-1:0] cnt_d [N];
  logic [N-1:0] lit_q;
  logic [N-1:0] lit_d;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_comb begin
        cnt_d[i] = cnt_q[i];
        if (sif.event_in[i]) begin
          cnt_d[i] = CW'(HOLD_CYC);
        end else if (cnt_q[i] != '0) begin
          cnt_d[i] = cnt_q[i] - CW'(1);
        end
        lit_d[i] = (cnt_d[i] != '0);
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_q[i] <= '0;
          lit_q[i] <= 1'b0;
        end else begin
          cnt_q[i] <= cnt_d[i];
          lit_q[i] <= lit_d[i];
        end
      end
    end
  endgenerate
  assign sif.lit = lit_q;
endmodule

// [logic/tai_stretch_if.sv]
// tai_stretch_if: carries pulse events into the stretcher and lit levels out.
// assumes the main module and stretcher share clk.
`timescale 1ns/10ps
interface tai_stretch_if #(parameter int unsigned N = 1);
  logic [N-1:0] event_in;
  logic [N-1:0] lit;
  modport src (output event_in, input lit);
  modport stretcher (input event_in, output lit);
endinterface

// [test/tai_far.sv]
// tai_far: far-end network and drop-insert line conditions.
// assumes the bench changes cond just after a clock edge.
`timescale 1ns/10ps
module tai_far (
  input wire logic [2:0] cond, // condition code
  output logic [8:0] st // loop,lock,frm,nopls,cfail,yellow,ais,conn,di
);
  // status levels seen by the engine for each condition
  always_comb begin
    case (cond)
      3'h1: st = 9'h033; // line lost
      3'h2: st = 9'h0cb; // far end yellow
      3'h3: st = 9'h087; // unframed all ones
      3'h4: st = 9'h0c2; // drop-insert frame lost
      3'h5: st = 9'h1c3; // looped back
      3'h6: st = 9'h0c1; // not connected
      default: st = 9'h0c3; // healthy
    endcase
  end
endmodule

// [test/tai_sva.sv]
// tai_sva: port checks for the indicator block.
// assumes one clk domain and a sync active-high sys_rst.
`timescale 1ns/10ps
module tai_sva (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic net_loopback, // loopback active
  input wire logic net_locked, // locked to rx
  input wire logic net_framed, // framing valid
  input wire logic net_no_pulses, // no pulses
  input wire logic net_carrier_fail, // carrier failure
  input wire logic di_frame_sync, // drop-insert sync
  input wire logic lan_evt, // lan event
  input wire logic setup_button, // setup button
  input wire logic test_indicator, // loopback lamp
  input wire logic sync_indicator, // sync lamp
  input wire logic los_indicator, // los lamp
  input wire logic red_alarm_indicator, // red lamp
  input wire logic drop_insert_frame_lock, // drop-insert lamp
  input wire logic lan_activity_indicator, // traffic lamp
  input wire logic setup_indicator, // setup lamp
  input wire logic setup_reset_mode, // long hold
  input wire logic tx_net_ais, // all-ones command
  input wire logic tx_yellow_alarm, // yellow command
  input wire logic tx_di_keepalive // keep-alive command
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // network lamps and alarm commands
  property p_test;
    !sys_rst |=> test_indicator == $past(net_loopback);
  endproperty
  a_test: assert property (p_test) else $error("test lamp wrong");
  property p_sync; sync_indicator |-> $past(net_locked && net_framed);
  endproperty
  a_sync: assert property (p_sync) else $error("sync lamp wrong");
  property p_los;
    !sys_rst && net_no_pulses |=> los_indicator && tx_net_ais;
  endproperty
  a_los: assert property (p_los) else $error("los response wrong");
  property p_red;
    !sys_rst && net_carrier_fail |=> red_alarm_indicator && tx_yellow_alarm;
  endproperty
  a_red: assert property (p_red) else $error("red alarm wrong");
  property p_no_yellow; !net_carrier_fail |=> !tx_yellow_alarm; endproperty
  a_no_yellow: assert property (p_no_yellow) else $error("yellow late");
  property p_di;
    !sys_rst && !di_frame_sync |=> tx_di_keepalive && !drop_insert_frame_lock;
  endproperty
  a_di: assert property (p_di) else $error("frame loss wrong");
  // activity stretch and setup button
  property p_lan;
    !sys_rst && lan_evt |=> lan_activity_indicator [*2];
  endproperty
  a_lan: assert property (p_lan) else $error("traffic too short");
  property p_setup; !setup_button |=> !setup_indicator && !setup_reset_mode;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not cleared");
  property p_hold; setup_reset_mode |-> $past(setup_button, 8); endproperty
  a_hold: assert property (p_hold) else $error("reset mode early");
  c_los: cover property (net_no_pulses ##1 tx_net_ais);
  c_lan: cover property (lan_evt ##1 lan_activity_indicator);
  c_hold: cover property (setup_reset_mode);
endmodule
bind tai_indicators tai_sva tai_sva_inst (.clk, .sys_rst, .net_loopback,
  .net_locked, .net_framed, .net_no_pulses, .net_carrier_fail,
  .di_frame_sync, .lan_evt, .setup_button, .test_indicator, .sync_indicator,
  .los_indicator, .red_alarm_indicator, .drop_insert_frame_lock,
  .lan_activity_indicator, .setup_indicator, .setup_reset_mode, .tx_net_ais,
  .tx_yellow_alarm, .tx_di_keepalive);

// [test/testbench.sv]
// testbench: self-checking bench for the indicator block.
// assumes short test parameters and the far-end model.
`timescale 1ns/10ps
module testbench;
  import tai_pkg::*;
  logic clk, sys_rst, lan_evt, setup_button, attention_needed, problem_present;
  logic diag_passed, module_reset_seen, net_loopback, net_locked;
  logic net_framed, net_no_pulses, net_carrier_fail, net_yellow_rx;
  logic net_ais_rx, net_connected, di_frame_sync, test_indicator;
  logic sync_indicator, los_indicator, red_alarm_indicator, online_indicator;
  logic remote_alarm_indicator, all_ones_alarm_indicator, tx_net_ais;
  logic drop_insert_frame_lock, attention_indicator, status_indicator;
  logic lan_activity_indicator, setup_indicator, setup_reset_mode;
  logic tx_yellow_alarm, tx_di_keepalive;
  logic [2:0] group_installed, eth_channel_sel, eth_channel_indicator;
  logic [2:0] cond, blink;
  logic [23:0] modem_good, modem_carrier, modem_tx_evt, modem_rx_evt;
  logic [23:0] modem_carrier_present, modem_tx_indicator, modem_rx_indicator;
  logic [1:0] group_color [NUM_GROUPS];
  logic [10:0] net_obs;
  logic [13:0] rows [7] = '{{3'h0, 11'h218}, {3'h1, 11'h19e},
    {3'h2, 11'h258}, {3'h3, 11'h038}, {3'h4, 11'h211}, {3'h5, 11'h618},
    {3'h6, 11'h208}};
  int num_errors, n_checks, cnt [3];
  // observed lamp groups
  assign net_obs = {test_indicator, sync_indicator, los_indicator,
    red_alarm_indicator, remote_alarm_indicator, all_ones_alarm_indicator,
    online_indicator, drop_insert_frame_lock, tx_net_ais, tx_yellow_alarm,
    tx_di_keepalive};
  assign blink = {setup_indicator, status_indicator, attention_indicator};
  tai_far tai_far_inst (.cond, .st({net_loopback, net_locked, net_framed,
    net_no_pulses, net_carrier_fail, net_yellow_rx, net_ais_rx,
    net_connected, di_frame_sync}));
  tai_indicators #(.HALF_PERIOD(4), .SETUP_HOLD(10), .STRETCH(3))
    tai_indicators_inst (.clk, .sys_rst, .group_installed, .modem_good,
    .modem_carrier, .modem_tx_evt, .modem_rx_evt, .net_loopback, .net_locked,
    .net_framed, .net_no_pulses, .net_carrier_fail, .net_yellow_rx,
    .net_ais_rx, .net_connected, .di_frame_sync, .attention_needed,
    .problem_present, .diag_passed, .module_reset_seen, .lan_evt,
    .setup_button, .eth_channel_sel, .group_color, .modem_carrier_present,
    .modem_tx_indicator, .modem_rx_indicator, .test_indicator,
    .sync_indicator, .los_indicator, .red_alarm_indicator,
    .remote_alarm_indicator, .all_ones_alarm_indicator, .online_indicator,
    .drop_insert_frame_lock, .attention_indicator, .status_indicator,
    .lan_activity_indicator, .setup_indicator, .eth_channel_indicator,
    .setup_reset_mode, .tx_net_ais, .tx_yellow_alarm, .tx_di_keepalive);
  // 125 MHz clock
  always #4 clk = ~clk;
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // count toggles of the regular flashers over 24 cycles
  task tog;
    logic [2:0] prev;
    cnt = '{0, 0, 0};
    @(negedge clk);
    prev = blink;
    repeat (24) begin
      @(negedge clk);
      for (int k = 0; k < 3; k++) cnt[k] += int'(blink[k] != prev[k]);
      prev = blink;
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    conclude;
  end
  // main sequence
  initial begin
    clk = 0; sys_rst = 1; cond = 0; group_installed = 3'h7;
    modem_good = '1; modem_carrier = 0; modem_tx_evt = 0; modem_rx_evt = 0;
    attention_needed = 0; problem_present = 0; diag_passed = 0; lan_evt = 0;
    module_reset_seen = 0; setup_button = 0; eth_channel_sel = 3'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) cond <= rows[i][13:11];
      settle(2);
      chk(net_obs, rows[i][10:0]);
    end
    $display("line table done");
    @(posedge clk) group_installed <= 3'h5;
    modem_good <= 24'hfffff7; modem_carrier <= 24'h800001;
    eth_channel_sel <= 3'h2;
    settle(2);
    chk(group_color[0], COLOR_AMBER);
    chk(group_color[1], COLOR_OFF);
    chk(group_color[2], COLOR_GREEN);
    chk(modem_carrier_present, 24'h800001);
    chk(eth_channel_indicator, 3'h2);
    $display("groups done");
    @(posedge clk) modem_tx_evt <= 24'h20;
    modem_rx_evt <= 24'h800000; lan_evt <= 1;
    @(posedge clk) modem_tx_evt <= 0;
    modem_rx_evt <= 0; lan_evt <= 0;
    settle(0);
    chk({modem_tx_indicator, modem_rx_indicator, lan_activity_indicator},
      {24'h20, 24'h800000, 1'b1});
    settle(2);
    chk({modem_tx_indicator, modem_rx_indicator, lan_activity_indicator},
      {24'h20, 24'h800000, 1'b1});
    settle(1);
    chk({modem_tx_indicator, modem_rx_indicator, lan_activity_indicator},
      49'h0);
    $display("activity done");
    @(posedge clk) problem_present <= 1;
    attention_needed <= 1; module_reset_seen <= 1;
    settle(3);
    tog;
    chk(cnt[0], 6);
    chk(cnt[1], 6);
    @(posedge clk) problem_present <= 0;
    diag_passed <= 1;
    settle(3);
    tog;
    chk({cnt[0][3:0], cnt[1][3:0], blink[1:0]}, 10'h003);
    @(posedge clk) setup_button <= 1;
    settle(2);
    chk({setup_reset_mode, setup_indicator}, 2'h1);
    settle(12);
    tog;
    chk({setup_reset_mode, cnt[2][3:0]}, 5'h16);
    @(posedge clk) setup_button <= 0;
    settle(2);
    chk({setup_reset_mode, setup_indicator}, 2'h0);
    $display("flashers done");
    @(posedge clk) cond <= 3'h5;
    sys_rst <= 1;
    settle(2);
    chk({net_obs, blink}, 14'h0);
    @(posedge clk) sys_rst <= 0;
    settle(2);
    chk(net_obs, 11'h618);
    $display("reset done");
    conclude;
  end
endmodule
